// ==== host_model.sv ====
// Purpose: Host side of the serial port
// Assumes: 8N1, LSB first
// Notes: Clear answer delayed by lag cycles
`timescale 1ns/1ps
module host_model #(
  parameter int BC = 50
) (
  input wire logic clk,
  input wire logic mode4,
  input wire logic txd,
  input wire logic dev_req_n,
  input wire logic dev_clr_n,
  output logic rxd,
  output logic req_n,
  output logic clr_n
);
  logic [7:0] got [$];
  int want = 0;
  int lag = 2;
  initial begin
    rxd = 1'b1;
    req_n = 1'b1;
    clr_n = 1'b1;
  end
  always @(posedge clk) begin
    if (!dev_req_n && clr_n && got.size() < want) begin
      repeat (lag) @(posedge clk);
      clr_n <= 1'b0;
    end else if (!clr_n && (mode4 ? got.size() >= want : dev_req_n)) begin
      clr_n <= 1'b1;
    end
  end
  always begin : rx_bits
    logic [7:0] b;
    @(negedge txd);
    repeat (BC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk);
      b[i] = txd;
    end
    repeat (BC) @(posedge clk);
    if (txd) got.push_back(b);
  end
  task automatic send(input logic [7:0] d [$], input int bc, output bit ok);
    int n;
    req_n <= 1'b0;
    for (n = 0; n < 20 && dev_clr_n !== 1'b0; n++) @(posedge clk);
    ok = (n < 20);
    foreach (d[i]) for (int k = 0; k < 10; k++) begin
      rxd <= k == 0 ? 1'b0 : (k == 9 ? 1'b1 : d[i][k-1]);
      repeat (bc) @(posedge clk);
    end
    repeat (2 * BC) @(posedge clk);
    req_n <= 1'b1;
    repeat (20 * BC) @(posedge clk);
  endtask : send
endmodule : host_model

// ==== host_uart_fc_ts.sv ====
// Purpose: Application serial port with two-pair flow control and timestamp packets
// Assumes: Pins are asynchronous to the core clock
// Notes: Transmit payload comes from the user port; time packets take priority
`timescale 1ns/1ps

// Functional notes
// - Receiver accepts bytes whose baud rate is within plus or minus two percent.
// - Transmit bit rate stays within one percent of nominal.
// - Accept-clear output follows host send request within two milliseconds.
// - Mode 4: device request held two bit periods after host clear drops.
// - Device starts a byte within two bit periods of host accept-clear.
// - Outside mode 4, device drops send request within one bit period after final stop bit.
// - Device leaves at least one idle bit period between its packets.
// - Time packet starts within 100 ms after strobe rising edge.
// - Timestamps count with one microsecond resolution.
module host_uart_fc_ts #(
  parameter int unsigned BIT_CYCLES = uart_pkg::DEFAULT_BIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic mode4_in,
  input wire logic rxd_in,
  input wire uart_pkg::hs_in_s hs_in,
  input wire uart_pkg::byte_s tx_byte_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic txd_out,
  output logic device_accept_clear_n_out,
  output logic device_send_request_n_out,
  output uart_pkg::byte_s rx_byte_out,
  output logic [31:0] time_us_out
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] s1_r, s2_r;
  logic rx_s, hreq_s, hclr_s, strobe_s, strobe_d_r;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r <= 4'hF;
      s2_r <= 4'hF;
      strobe_d_r <= 1'b1;
    end else begin
      s1_r <= {rxd_in, hs_in.host_send_request_n, hs_in.host_accept_clear_n, hs_in.timestamp_request_strobe_n};
      s2_r <= s1_r;
      strobe_d_r <= s2_r[0];
    end
  end
  assign rx_s = s2_r[3];
  assign hreq_s = !s2_r[2];
  assign hclr_s = !s2_r[1];
  assign strobe_s = s2_r[0];

  // ****************************************
  // Receiver
  // ****************************************
  uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .rxd_in(rx_s),
    .byte_out(rx_byte_out)
  );

  // ****************************************
  // Microsecond timebase and receive handshake
  // ****************************************
  logic [7:0] us_cnt_r, us_cnt_nxt;
  logic [31:0] time_r, time_nxt, snap_r, snap_nxt;
  logic acc_n_r, acc_n_nxt;
  logic ts_pend_r, ts_pend_nxt;
  logic ts_done;
  always_comb begin
    us_cnt_nxt = us_cnt_r + 8'h01;
    time_nxt = time_r;
    if (us_cnt_r == 8'(uart_pkg::US_CYCLES - 1)) begin
      us_cnt_nxt = 8'h00;
      time_nxt = time_r + 32'h0000_0001;
    end
    // Clear follows request after the synchroniser, far under 2 ms
    acc_n_nxt = !hreq_s;
    snap_nxt = snap_r;
    ts_pend_nxt = ts_pend_r;
    if (strobe_s && !strobe_d_r) begin
      snap_nxt = time_r;
      ts_pend_nxt = 1'b1;
    end else if (ts_done) begin
      ts_pend_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      us_cnt_r <= 8'h00;
      time_r <= 32'h0000_0000;
      snap_r <= 32'h0000_0000;
      acc_n_r <= 1'b1;
      ts_pend_r <= 1'b0;
    end else begin
      us_cnt_r <= us_cnt_nxt;
      time_r <= time_nxt;
      snap_r <= snap_nxt;
      acc_n_r <= acc_n_nxt;
      ts_pend_r <= ts_pend_nxt;
    end
  end
  assign time_us_out = time_r;
  assign device_accept_clear_n_out = acc_n_r;

  // ****************************************
  // Transmitter with request/clear handshake
  // ****************************************
  typedef enum logic [2:0] {T_IDLE, T_WAIT, T_SHIFT, T_HOLD, T_GAP} tx_state_e;
  tx_state_e ts_r, ts_nxt;
  logic [15:0] bc_r, bc_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [9:0] sh_r, sh_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic is_time_r, is_time_nxt, last_r, last_nxt;
  logic req_r, req_nxt, txd_r, txd_nxt, rdy_r, rdy_nxt;
  logic req_n_r, req_n_nxt;
  logic [1:0] hold_r, hold_nxt;
  logic [7:0] tbyte;
  localparam logic [15:0] BFULL = 16'(BIT_CYCLES - 1);

  always_comb begin
    unique case (idx_r)
      3'h0: tbyte = uart_pkg::TIME_TAG;
      3'h1: tbyte = snap_r[31:24];
      3'h2: tbyte = snap_r[23:16];
      3'h3: tbyte = snap_r[15:8];
      default: tbyte = snap_r[7:0];
    endcase
  end
  assign ts_done = (ts_r == T_GAP) && is_time_r && (bc_r == 16'h0000);

  always_comb begin
    ts_nxt = ts_r;
    bc_nxt = (bc_r == 16'h0000) ? BFULL : bc_r - 16'h0001;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    is_time_nxt = is_time_r;
    last_nxt = last_r;
    req_nxt = req_r;
    txd_nxt = txd_r;
    hold_nxt = hold_r;
    rdy_nxt = 1'b0;
    unique case (ts_r)
      T_IDLE: begin
        if (ts_pend_r) begin
          is_time_nxt = 1'b1;
          idx_nxt = 3'h0;
          req_nxt = 1'b1;
          ts_nxt = T_WAIT;
        end else if (tx_byte_in.valid) begin
          is_time_nxt = 1'b0;
          req_nxt = 1'b1;
          ts_nxt = T_WAIT;
        end
      end
      T_WAIT: begin
        if (hclr_s && (is_time_r || tx_byte_in.valid)) begin
          // Byte starts at once when clear is seen
          if (is_time_r) begin
            sh_nxt = {1'b1, tbyte, 1'b0};
            last_nxt = (idx_r == 3'(uart_pkg::TIME_BYTES));
            idx_nxt = idx_r + 3'h1;
          end else begin
            sh_nxt = {1'b1, tx_byte_in.data, 1'b0};
            last_nxt = tx_last_in;
            rdy_nxt = 1'b1;
          end
          bit_nxt = 4'h0;
          bc_nxt = BFULL;
          txd_nxt = 1'b0;
          ts_nxt = T_SHIFT;
        end
      end
      T_SHIFT: begin
        if (bc_r == 16'h0000) begin
          bit_nxt = bit_r + 4'h1;
          sh_nxt = {1'b1, sh_r[9:1]};
          txd_nxt = sh_r[1];
          if (bit_r == 4'h9) begin
            txd_nxt = 1'b1;
            if (last_r) begin
              hold_nxt = 2'h0;
              ts_nxt = T_HOLD;
            end else begin
              ts_nxt = T_WAIT;
            end
          end
        end
      end
      T_HOLD: begin
        if (!mode4_in) begin
          req_nxt = 1'b0;
          ts_nxt = T_GAP;
        end else if (hclr_s) begin
          // Hold count restarts from a whole bit once clear drops
          hold_nxt = 2'h0;
          bc_nxt = BFULL;
        end else if (bc_r == 16'h0000) begin
          hold_nxt = hold_r + 2'h1;
          if (hold_r == 2'(uart_pkg::RTS_HOLD_BITS - 1)) begin
            req_nxt = 1'b0;
            ts_nxt = T_GAP;
          end
        end
      end
      T_GAP: begin
        if (bc_r == 16'h0000 && !(hclr_s && !mode4_in)) begin
          ts_nxt = T_IDLE;
        end
      end
      default: ts_nxt = T_IDLE;
    endcase
    req_n_nxt = !req_nxt;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ts_r <= T_IDLE;
      bc_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 10'h3FF;
      idx_r <= 3'h0;
      is_time_r <= 1'b0;
      last_r <= 1'b0;
      req_r <= 1'b0;
      req_n_r <= 1'b1;
      txd_r <= 1'b1;
      hold_r <= 2'h0;
      rdy_r <= 1'b0;
    end else begin
      ts_r <= ts_nxt;
      bc_r <= bc_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      is_time_r <= is_time_nxt;
      last_r <= last_nxt;
      req_r <= req_nxt;
      req_n_r <= req_n_nxt;
      txd_r <= txd_nxt;
      hold_r <= hold_nxt;
      rdy_r <= rdy_nxt;
    end
  end
  assign txd_out = txd_r;
  assign tx_ready_out = rdy_r;
  assign device_send_request_n_out = req_n_r;
endmodule : host_uart_fc_ts

// ==== host_uart_fc_ts_properties.sv ====
// Purpose: Port checker for host_uart_fc_ts
// Assumes: One clock, async low reset
// Notes: Bound after endmodule
`timescale 1ns/1ps
module host_uart_fc_ts_checker #(
  parameter int unsigned BIT_CYCLES = uart_pkg::DEFAULT_BIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic mode4_in,
  input wire logic rxd_in,
  input wire uart_pkg::hs_in_s hs_in,
  input wire uart_pkg::byte_s tx_byte_in,
  input wire logic tx_last_in,
  input wire logic tx_ready_out,
  input wire logic txd_out,
  input wire logic device_accept_clear_n_out,
  input wire logic device_send_request_n_out,
  input wire uart_pkg::byte_s rx_byte_out,
  input wire logic [31:0] time_us_out
);
  localparam int WB = 2 * BIT_CYCLES + 4;
  localparam int US = uart_pkg::US_CYCLES;
  int ch_r;
  int ch_nxt;
  int hi_r;
  int hi_nxt;
  logic req_d_r;
  logic end_r;
  logic end_nxt;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Cycles the host clear has stayed high
  always_comb begin
    ch_nxt = hs_in.host_accept_clear_n ? ch_r + 1 : 0;
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ch_r <= 0;
    end else begin
      ch_r <= ch_nxt;
    end
  end
  // Cycles the serial output has stayed high, and packet-end flag
  always_comb begin
    hi_nxt = txd_out ? hi_r + 1 : 0;
    end_nxt = end_r;
    if (device_send_request_n_out && !req_d_r) begin
      end_nxt = 1'b1;
    end else if (!txd_out) begin
      end_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_r <= 0;
      req_d_r <= 1'b1;
      end_r <= 1'b0;
    end else begin
      hi_r <= hi_nxt;
      req_d_r <= device_send_request_n_out;
      end_r <= end_nxt;
    end
  end
  sequence s_clr_on; $fell(hs_in.host_accept_clear_n) && !device_send_request_n_out; endsequence
  property p_con; $fell(hs_in.host_send_request_n) |-> ##[1:4] !device_accept_clear_n_out; endproperty
  a_con: assert property (p_con) else $error("accept clear late");
  property p_coff; $rose(hs_in.host_send_request_n) |-> ##[1:4] device_accept_clear_n_out; endproperty
  a_coff: assert property (p_coff) else $error("accept clear stuck");
  property p_txr; !txd_out |-> !device_send_request_n_out; endproperty
  a_txr: assert property (p_txr) else $error("send without request");
  property p_start; s_clr_on |-> ##[1:WB] !txd_out; endproperty
  a_start: assert property (p_start) else $error("start bit late");
  property p_hold; $rose(device_send_request_n_out) && mode4_in |-> ch_r >= 2 * BIT_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_ts; $rose(hs_in.timestamp_request_strobe_n) |-> ##[1:1000] !txd_out; endproperty
  a_ts: assert property (p_ts) else $error("time packet late");
  property p_step; $changed(time_us_out) |-> time_us_out == $past(time_us_out) + 1; endproperty
  a_step: assert property (p_step) else $error("time step wrong");
  property p_tick; $changed(time_us_out) |-> ##[1:US] $changed(time_us_out); endproperty
  a_tick: assert property (p_tick) else $error("time tick late");
  property p_gap; $fell(txd_out) && end_r |-> hi_r >= 2 * BIT_CYCLES; endproperty
  a_gap: assert property (p_gap) else $error("packet gap short");
endmodule : host_uart_fc_ts_checker

bind host_uart_fc_ts host_uart_fc_ts_checker #(.BIT_CYCLES(BIT_CYCLES)) chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .mode4_in(mode4_in), .rxd_in(rxd_in),
  .hs_in(hs_in), .tx_byte_in(tx_byte_in), .tx_last_in(tx_last_in), .tx_ready_out(tx_ready_out),
  .txd_out(txd_out), .device_accept_clear_n_out(device_accept_clear_n_out),
  .device_send_request_n_out(device_send_request_n_out), .rx_byte_out(rx_byte_out),
  .time_us_out(time_us_out));

// ==== host_uart_flow_control_timestamp_bench.sv ====
// Purpose: Self-checking bench for host_uart_fc_ts
// Assumes: Bit period scaled to 50 cycles
// Notes: Host side is host_model
`timescale 1ns/1ps
module host_uart_flow_control_timestamp_bench;
  localparam int BC = 50;
  typedef struct packed {
    logic m4;
    logic [7:0] bc;
    logic [7:0] d;
  } row_s;
  localparam row_s ROWS [4] = '{'{1'b0, 8'h31, 8'h5A}, '{1'b0, 8'h33, 8'hA3}, '{1'b1, 8'h32, 8'hFF},
                                '{1'b1, 8'h31, 8'h00}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic m4 = 1'b0;
  logic stb_n = 1'b1;
  logic last = 1'b0;
  logic rxd, hreq_n, hclr_n, rdy, txd, clr_n, req_n;
  logic [31:0] tus;
  uart_pkg::byte_s txb = '0;
  uart_pkg::byte_s rxb;
  uart_pkg::hs_in_s hs;
  logic [7:0] rxq [$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  bit ok;
  assign hs = '{host_send_request_n: hreq_n, host_accept_clear_n: hclr_n, timestamp_request_strobe_n: stb_n};
  host_uart_fc_ts #(.BIT_CYCLES(BC)) dut (.core_clk_in(clk), .arst_n_in(rst_n), .mode4_in(m4), .rxd_in(rxd),
    .hs_in(hs), .tx_byte_in(txb), .tx_last_in(last), .tx_ready_out(rdy), .txd_out(txd),
    .device_accept_clear_n_out(clr_n), .device_send_request_n_out(req_n), .rx_byte_out(rxb), .time_us_out(tus));
  host_model #(.BC(BC)) host (.clk(clk), .mode4(m4), .txd(txd), .dev_req_n(req_n), .dev_clr_n(clr_n),
    .rxd(rxd), .req_n(hreq_n), .clr_n(hclr_n));
  initial forever #4 clk = ~clk;
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;
  always @(negedge clk) if (rxb.valid === 1'b1) rxq.push_back(rxb.data);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 9000 && host.got.size() < n; k++) @(posedge clk);
    check("host bytes", host.got.size() >= n, 1'b1);
    if (k == 9000) end_sim();
  endtask : wait_got
  task automatic dev_send(input logic [7:0] d [$]);
    int n;
    foreach (d[i]) begin
      txb <= '{valid: 1'b1, data: d[i]};
      last <= (i == d.size() - 1);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (rdy !== 1'b1 && n < 9000);
      check("ready", rdy, 1'b1);
      if (rdy !== 1'b1) end_sim();
      @(posedge clk);
    end
    txb <= '0;
    last <= 1'b0;
    @(posedge clk);
  endtask : dev_send
  initial begin
    logic [7:0] q [$];
    logic [31:0] ts;
    int exp;
    repeat (9) @(posedge clk);
    @(negedge clk);
    check("reset outs", {txd, clr_n, req_n, rdy, rxb.valid}, 5'h1C);
    check("reset time", tus, 32'h0);
    $display("reset done");
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ROWS[i]) begin
      m4 <= ROWS[i].m4;
      host.got.delete();
      host.want = 1;
      dev_send('{ROWS[i].d});
      wait_got(1);
      check("tx byte", host.got[0], ROWS[i].d);
      host.send('{ROWS[i].d}, ROWS[i].bc, ok);
      check("accept", ok, 1'b1);
      check("rx count", rxq.size(), 1);
      check("rx byte", rxq.pop_front(), ROWS[i].d);
      $display("row %0d done", i);
    end
    m4 <= 1'b0;
    host.got.delete();
    host.want = 5;
    host.lag = 40;
    q = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    dev_send(q[0:2]);
    dev_send(q[3:4]);
    wait_got(5);
    repeat (BC) @(posedge clk);
    check("req drop", req_n, 1'b1);
    foreach (q[i]) check("burst", host.got[i], q[i]);
    host.send(q, 49, ok);
    check("accept", ok, 1'b1);
    foreach (q[i]) check("rx burst", rxq.pop_front(), q[i]);
    $display("burst done");
    m4 <= 1'b1;
    host.lag = 2;
    host.got.delete();
    stb_n <= 1'b0;
    repeat (15700) @(posedge clk);
    stb_n <= 1'b1;
    exp = cyc / uart_pkg::US_CYCLES;
    wait_got(5);
    repeat (BC) @(posedge clk);
    check("req hold", req_n, 1'b0);
    repeat (2 * BC) @(posedge clk);
    check("req drop", req_n, 1'b1);
    ts = {host.got[1], host.got[2], host.got[3], host.got[4]};
    check("time tag", host.got[0], uart_pkg::TIME_TAG);
    check("time near", ts - exp + 1 <= 2, 1'b1);
    $display("time packet done");
    end_sim();
  end
endmodule : host_uart_flow_control_timestamp_bench

// ==== uart_pkg.sv ====
// Purpose: Shared constants and carriers for the host serial port with flow control and timestamp
// Assumes: 125 MHz core clock
// Notes: Request and clear pins are active low at the pins; the timestamp strobe acts on its rising edge
package uart_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ACCEPT_DELAY_MS = 2;
  localparam int unsigned TIMESTAMP_US_NS = 1000;
  localparam int unsigned US_CYCLES = (TIMESTAMP_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCEPT_SYNC_CYCLES = 3;
  localparam int unsigned DEFAULT_BAUD = 115200;
  localparam int unsigned DEFAULT_BIT_CYCLES = CLK_HZ / DEFAULT_BAUD;
  localparam int unsigned RTS_HOLD_BITS = 2;
  localparam int unsigned INTERPACKET_BITS = 1;
  localparam int unsigned TIME_BYTES = 4;
  localparam logic [7:0] TIME_TAG = 8'hA5;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_s;

  typedef struct packed {
    logic host_send_request_n;
    logic host_accept_clear_n;
    logic timestamp_request_strobe_n;
  } hs_in_s;

endpackage : uart_pkg

// ==== uart_rx.sv ====
// Purpose: Serial byte receiver sampling at mid-bit
// Assumes: Input already synchronised to the core clock
// Notes: Mid-bit sampling gives tolerance well beyond two percent
`timescale 1ns/1ps
module uart_rx #(
  parameter int unsigned BIT_CYCLES = uart_pkg::DEFAULT_BIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic rxd_in,
  output uart_pkg::byte_s byte_out
);
  typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_e;
  rx_state_e state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  uart_pkg::byte_s out_r, out_nxt;
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);

  assign byte_out = out_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    out_nxt = '{valid: 1'b0, data: out_r.data};
    unique case (state_r)
      IDLE: begin
        if (!rxd_in) begin
          state_nxt = START;
          cnt_nxt = HALF;
        end
      end
      START: begin
        if (cnt_r == 16'h0000) begin
          // Mid-bit sampling recentres on each start edge
          state_nxt = rxd_in ? IDLE : DATA;
          cnt_nxt = FULL;
          bit_nxt = 3'h0;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      DATA: begin
        if (cnt_r == 16'h0000) begin
          sh_nxt = {rxd_in, sh_r[7:1]};
          cnt_nxt = FULL;
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            state_nxt = STOP;
          end
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      STOP: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = IDLE;
          if (rxd_in) begin
            out_nxt = '{valid: 1'b1, data: sh_r};
          end
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= IDLE;
      cnt_r <= 16'h0000;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      out_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
    end
  end
endmodule : uart_rx
